// *** hw/fcc_pkg.sv ***
// package: shared constants for the cache, tcm and micro-tlb subsystem
package fcc_pkg;
  // ------------------------------------------------------------
  // address layout
  // ------------------------------------------------------------
  localparam int OFFSET_W      = 5;
  localparam int LINE_BYTES    = 32;
  localparam int LINE_WORDS    = 8;
  localparam int WORD_SEL_W    = 3;
  localparam int ADDR_W_NOMMU  = 31;
  localparam int ADDR_W_MMU    = 32;
  localparam int BYPASS_BIT    = 31;
  localparam int PAGE_W        = 12;
  localparam int VPN_W         = 20;
  localparam int PFN_W         = 20;
  // ------------------------------------------------------------
  // defaults
  // ------------------------------------------------------------
  localparam int DUTLB_DEF     = 6;
  localparam int IUTLB_DEF     = 4;
  localparam int TCM_MAX       = 4;

  // data side control operations
  typedef enum logic [2:0] {
    FCC_OP_LOAD    = 3'h0,
    FCC_OP_STORE   = 3'h1,
    FCC_OP_FLUSHD  = 3'h2,
    FCC_OP_FLUSHDA = 3'h3,
    FCC_OP_INITD   = 3'h4,
    FCC_OP_INITDA  = 3'h5
  } fcc_op_t;

  // data cache sequencer, codes gray in declaration order; returns to idle change two bits
  typedef enum logic [2:0] {
    FCC_D_IDLE  = 3'b000,
    FCC_D_WBACK = 3'b001,
    FCC_D_FILL  = 3'b011,
    FCC_D_BYP   = 3'b010,
    FCC_D_DONE  = 3'b110
  } fcc_dstate_t;

  typedef enum logic [1:0] {
    FCC_I_IDLE = 2'b00,
    FCC_I_FILL = 2'b01,
    FCC_I_DONE = 2'b11
  } fcc_istate_t;
endpackage

// *** hw/fcc_core_mem.sv ***
// module: cache, tcm decode and micro-tlb memory subsystem of the core
// What this block does
// RQ1 - instruction cache is direct mapped, eight words per 32-byte line
// RQ2 - icache miss fetches whole line, one read per clock, critical word first
// RQ3 - offset is five bits, index from cache size, tag the rest
// RQ4 - addresses 31 bits without translation, 32 with; tag covers frame number
// RQ5 - with translation, index by virtual bits and tag by physical bits
// RQ6 - icache optional; without it an instruction tcm must exist
// RQ7 - data cache direct mapped, 32-byte lines, write back dirty lines only
// RQ8 - store miss allocates line, filled by one read per clock
// RQ9 - data line fill reads whole line at one read per clock
// RQ10 - data cache optional; without it every non-tcm load and store goes to the data master
// RQ11 - four clearing ops: tag ignored or compared, with or without writeback
// RQ12 - bypass accesses go straight to data master without allocating
// RQ13 - software should flush a line before mixing uncached accesses
// RQ14 - data master burst option only allowed with data cache
// RQ15 - up to four instruction and four data tcm ports, one slave each
// RQ16 - fetch and data addresses decoded internally to tcm spans
// RQ17 - tcm accesses bypass caches; cache ops on tcm addresses do nothing
// RQ18 - with translation, tcm reachable only in supervisor mode
// RQ19 - fully associative micro tlbs in registers, six data, four instruction
// RQ20 - new micro tlb entry replaces least recently used
// RQ21 - micro tlb first, then main tlb; main miss raises exception
// RQ22 - both micro tlbs flushed on main tlb write or misc register write
// RQ23 - without translation, data bit 31 selects cache bypass
// RQ24 - masters are pipelined, new reads issue before data returns
// RQ25 - after reset every cache line is invalid
module fcc_core_mem
  import fcc_pkg::*;
#(
  parameter int          HAS_MMU    = 0,
  parameter int          HAS_ICACHE = 1,
  parameter int          HAS_DCACHE = 1,
  parameter int          BURST_EN   = 0,
  parameter int          ISETS      = 16,
  parameter int          DSETS      = 16,
  parameter int          N_ITCM     = 1,
  parameter int          N_DTCM     = 1,
  parameter int          IUTLB_N    = IUTLB_DEF,
  parameter int          DUTLB_N    = DUTLB_DEF,
  parameter logic [31:0] ITCM_BASE  = 32'h0001_0000,
  parameter logic [31:0] DTCM_BASE  = 32'h0002_0000,
  parameter logic [31:0] TCM_SPAN   = 32'h0000_1000
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              supervisor,
  input  wire logic              if_req,
  input  wire logic [31:0]       if_addr,
  output logic                   if_ack,
  output logic [31:0]            if_rdata,
  output logic                   if_fault,
  input  wire logic              ls_req,
  input  wire logic [2:0]        ls_op,
  input  wire logic              ls_bypass,
  input  wire logic [31:0]       ls_addr,
  input  wire logic [31:0]       ls_wdata,
  input  wire logic [3:0]        ls_be,
  output logic                   ls_ack,
  output logic [31:0]            ls_rdata,
  output logic                   ls_fault,
  output logic                   mtlb_req,
  output logic [VPN_W-1:0]       mtlb_vpn,
  input  wire logic              mtlb_hit,
  input  wire logic [PFN_W-1:0]  mtlb_pfn,
  input  wire logic              tlb_write,
  input  wire logic              tlbmisc_write,
  output logic                   im_read,
  output logic [31:0]            im_address,
  input  wire logic              im_waitrequest,
  input  wire logic              im_readdatavalid,
  input  wire logic [31:0]       im_readdata,
  output logic                   dm_read,
  output logic                   dm_write,
  output logic [31:0]            dm_address,
  output logic [31:0]            dm_writedata,
  output logic [3:0]             dm_byteenable,
  input  wire logic              dm_waitrequest,
  input  wire logic              dm_readdatavalid,
  input  wire logic [31:0]       dm_readdata,
  output logic [N_ITCM-1:0]      itcm_read,
  output logic [31:0]            itcm_address,
  input  wire logic [N_ITCM*32-1:0] itcm_readdata,
  output logic [N_DTCM-1:0]      dtcm_read,
  output logic [N_DTCM-1:0]      dtcm_write,
  output logic [31:0]            dtcm_address,
  output logic [31:0]            dtcm_writedata,
  output logic [3:0]             dtcm_byteenable,
  input  wire logic [N_DTCM*32-1:0] dtcm_readdata
);
  // ------------------------------------------------------------
  // build checks
  // ------------------------------------------------------------
  // RQ3 field widths
  localparam int IIDX_W = $clog2(ISETS);
  localparam int DIDX_W = $clog2(DSETS);
  localparam int ITAG_W = 32 - OFFSET_W - IIDX_W;
  localparam int DTAG_W = 32 - OFFSET_W - DIDX_W;
  // RQ6 instruction store present
  if (HAS_ICACHE == 0 && N_ITCM < 1) $error("no icache needs an itcm");
  // RQ15 tcm port count
  if (N_ITCM > TCM_MAX || N_DTCM > TCM_MAX || N_ITCM < 1 || N_DTCM < 1)
    $error("tcm port count out of range");
  // RQ14 burst needs dcache
  if (BURST_EN != 0 && HAS_DCACHE == 0) $error("burst needs data cache");
  if (IUTLB_N < 2 || DUTLB_N < 2 || ISETS < 2 || DSETS < 2) $error("bad size");

  // ------------------------------------------------------------
  // address helpers
  // ------------------------------------------------------------
  // RQ4 address width
  function automatic logic [31:0] phys_of(input logic [31:0] a, input logic [PFN_W-1:0] f);
    if (HAS_MMU != 0) phys_of = {f, a[PAGE_W-1:0]};
    else              phys_of = {1'b0, a[ADDR_W_NOMMU-1:0]};
  endfunction
  // RQ16 tcm span decode
  function automatic logic in_span(input logic [31:0] a, input logic [31:0] b);
    in_span = (a >= b) && (a - b < TCM_SPAN);
  endfunction

  // ------------------------------------------------------------
  // micro tlbs
  // ------------------------------------------------------------
  // RQ19 register based, fully associative
  logic [VPN_W-1:0] iu_vpn_q [IUTLB_N];
  logic [PFN_W-1:0] iu_pfn_q [IUTLB_N];
  logic [IUTLB_N-1:0] iu_val_q;
  logic [7:0]       iu_age_q [IUTLB_N];
  logic [VPN_W-1:0] du_vpn_q [DUTLB_N];
  logic [PFN_W-1:0] du_pfn_q [DUTLB_N];
  logic [DUTLB_N-1:0] du_val_q;
  logic [7:0]       du_age_q [DUTLB_N];

  logic             i_hit, d_hit;
  logic [PFN_W-1:0] i_pfn, d_pfn;
  int               i_hidx, d_hidx, i_lru, d_lru;
  always_comb
  begin
    i_hit = 1'b0; i_pfn = '0; i_hidx = 0; i_lru = 0;
    for (int k = 0; k < IUTLB_N; k++)
    begin
      if (iu_val_q[k] && iu_vpn_q[k] == if_addr[31:PAGE_W])
      begin
        i_hit = 1'b1; i_pfn = iu_pfn_q[k]; i_hidx = k;
      end
      if (iu_age_q[k] > iu_age_q[i_lru]) i_lru = k;
    end
    d_hit = 1'b0; d_pfn = '0; d_hidx = 0; d_lru = 0;
    for (int k = 0; k < DUTLB_N; k++)
    begin
      if (du_val_q[k] && du_vpn_q[k] == ls_addr[31:PAGE_W])
      begin
        d_hit = 1'b1; d_pfn = du_pfn_q[k]; d_hidx = k;
      end
      if (du_age_q[k] > du_age_q[d_lru]) d_lru = k;
    end
  end

  // without translation the micro tlbs stand aside
  wire i_xlat_ok = (HAS_MMU == 0) || i_hit;
  wire d_xlat_ok = (HAS_MMU == 0) || d_hit;
  // RQ21 main tlb consulted on micro miss, data side first
  wire d_need = (HAS_MMU != 0) && ls_req && !d_hit;
  wire i_need = (HAS_MMU != 0) && if_req && !i_hit && !d_need;
  assign mtlb_req = d_need || i_need;
  assign mtlb_vpn = d_need ? ls_addr[31:PAGE_W] : if_addr[31:PAGE_W];
  wire tlb_flush = tlb_write || tlbmisc_write;

  always_ff @(posedge clk)
  begin
    // RQ22 flush both on tlb maintenance
    if (rst || tlb_flush)
    begin
      iu_val_q <= '0;
      du_val_q <= '0;
      for (int k = 0; k < IUTLB_N; k++) iu_age_q[k] <= 8'(k);
      for (int k = 0; k < DUTLB_N; k++) du_age_q[k] <= 8'(k);
    end
    else
    begin
      // RQ20 lru aging: used entry to zero, younger ones age
      if (if_req && i_hit)
        for (int k = 0; k < IUTLB_N; k++)
          iu_age_q[k] <= (k == i_hidx) ? 8'h00 :
                         (iu_age_q[k] < iu_age_q[i_hidx]) ? iu_age_q[k] + 8'h01 : iu_age_q[k];
      else if (i_need && mtlb_hit)
      begin
        iu_val_q[i_lru] <= 1'b1;
        iu_vpn_q[i_lru] <= if_addr[31:PAGE_W];
        iu_pfn_q[i_lru] <= mtlb_pfn;
      end
      if (ls_req && d_hit)
        for (int k = 0; k < DUTLB_N; k++)
          du_age_q[k] <= (k == d_hidx) ? 8'h00 :
                         (du_age_q[k] < du_age_q[d_hidx]) ? du_age_q[k] + 8'h01 : du_age_q[k];
      else if (d_need && mtlb_hit)
      begin
        du_val_q[d_lru] <= 1'b1;
        du_vpn_q[d_lru] <= ls_addr[31:PAGE_W];
        du_pfn_q[d_lru] <= mtlb_pfn;
      end
    end
  end

  // ------------------------------------------------------------
  // instruction side
  // ------------------------------------------------------------
  // RQ5 virtual index, physical tag
  wire [31:0]       if_pa    = phys_of(if_addr, i_pfn);
  wire [IIDX_W-1:0] if_idx   = if_addr[OFFSET_W +: IIDX_W];
  wire [ITAG_W-1:0] if_tag   = if_pa[31 -: ITAG_W];
  wire              if_ghost = (HAS_MMU != 0) && !supervisor;
  logic [N_ITCM-1:0] if_tsel;
  for (genvar g = 0; g < N_ITCM; g++)
  begin : g_itcm
    // RQ18 tcm supervisor only
    assign if_tsel[g] = in_span(if_pa, ITCM_BASE + 32'(g) * TCM_SPAN) && !if_ghost;
  end

  // RQ1 direct mapped line store
  logic [31:0]       ic_data_q [ISETS*LINE_WORDS];
  logic [ITAG_W-1:0] ic_tag_q  [ISETS];
  logic [ISETS-1:0]  ic_val_q;
  fcc_istate_t       is_q;
  logic [3:0]        i_issued_q, i_got_q;
  logic [31:0]       i_base_q;
  logic [2:0]        i_crit_q;
  wire [2:0]  if_word = if_addr[OFFSET_W-1:2];
  wire        ic_hit  = ic_val_q[if_idx] && ic_tag_q[if_idx] == if_tag && HAS_ICACHE != 0;
  wire        i_tcm   = |if_tsel;
  wire        i_go    = if_req && i_xlat_ok && is_q == FCC_I_IDLE;
  // RQ2 critical word first, wrapping
  wire [2:0]  i_wsel  = 3'(i_crit_q + i_issued_q[2:0]);
  assign im_read    = is_q == FCC_I_FILL && i_issued_q < 4'(LINE_WORDS);
  assign im_address = {i_base_q[31:OFFSET_W], i_wsel, 2'b00};
  assign itcm_read    = i_go ? if_tsel : '0;
  assign itcm_address = if_pa;
  assign if_fault   = (HAS_MMU != 0) && (i_need && !mtlb_hit);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // RQ25 all lines invalid
      ic_val_q <= '0;
      is_q <= FCC_I_IDLE;
      i_issued_q <= '0; i_got_q <= '0; i_base_q <= '0; i_crit_q <= '0;
      if_ack <= 1'b0; if_rdata <= '0;
    end
    else
    begin
      if_ack <= 1'b0;
      unique case (is_q)
        FCC_I_IDLE:
          if (i_go && i_tcm)
          begin
            // RQ17 tcm served without touching cache
            if_ack <= 1'b1;
            for (int k = 0; k < N_ITCM; k++)
              if (if_tsel[k]) if_rdata <= itcm_readdata[k*32 +: 32];
          end
          else if (i_go && ic_hit)
          begin
            if_ack <= 1'b1;
            if_rdata <= ic_data_q[{if_idx, if_word}];
          end
          else if (i_go && HAS_ICACHE != 0)
          begin
            is_q <= FCC_I_FILL;
            i_base_q <= if_pa; i_crit_q <= if_word;
            i_issued_q <= '0; i_got_q <= '0;
            ic_val_q[if_idx] <= 1'b0;
          end
        FCC_I_FILL:
        begin
          // RQ24 reads issue ahead of returning data
          if (im_read && !im_waitrequest) i_issued_q <= i_issued_q + 4'h1;
          if (im_readdatavalid)
          begin
            ic_data_q[{if_idx, 3'(i_crit_q + i_got_q[2:0])}] <= im_readdata;
            i_got_q <= i_got_q + 4'h1;
            if (i_got_q == 4'(LINE_WORDS - 1))
            begin
              ic_tag_q[if_idx] <= if_tag;
              ic_val_q[if_idx] <= 1'b1;
              is_q <= FCC_I_DONE;
            end
          end
        end
        FCC_I_DONE: is_q <= FCC_I_IDLE;
        default:    is_q <= FCC_I_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // data side
  // ------------------------------------------------------------
  wire [31:0]       ls_pa  = phys_of(ls_addr, d_pfn);
  wire [DIDX_W-1:0] ls_idx = ls_addr[OFFSET_W +: DIDX_W];
  wire [DTAG_W-1:0] ls_tag = ls_pa[31 -: DTAG_W];
  wire [2:0]        ls_word = ls_addr[OFFSET_W-1:2];
  logic [N_DTCM-1:0] ls_tsel;
  for (genvar g = 0; g < N_DTCM; g++)
  begin : g_dtcm
    assign ls_tsel[g] = in_span(ls_pa, DTCM_BASE + 32'(g) * TCM_SPAN)
                        && !((HAS_MMU != 0) && !supervisor);
  end

  // RQ7 direct mapped, dirty bits for write back
  logic [31:0]       dc_data_q [DSETS*LINE_WORDS];
  logic [DTAG_W-1:0] dc_tag_q  [DSETS];
  logic [DSETS-1:0]  dc_val_q, dc_dirty_q;
  fcc_dstate_t       ds_q;
  logic [3:0]        d_cnt_q, d_got_q;
  logic [DIDX_W-1:0] d_idx_q;
  logic              d_fill_q;

  fcc_op_t op;
  assign op = fcc_op_t'(ls_op);
  // RQ10 RQ23 no dcache or bit 31
  wire d_byp = HAS_DCACHE == 0 || ls_bypass || ((HAS_MMU == 0) && ls_addr[BYPASS_BIT]);
  wire d_tag_eq = dc_val_q[ls_idx] && dc_tag_q[ls_idx] == ls_tag;
  wire is_mem   = op == FCC_OP_LOAD || op == FCC_OP_STORE;
  wire d_go     = ls_req && d_xlat_ok && ds_q == FCC_D_IDLE;
  wire d_tcm    = |ls_tsel;
  // RQ11 tag ignored for flushd and initd, compared for the -a forms
  wire cl_match = (op == FCC_OP_FLUSHD || op == FCC_OP_INITD) || d_tag_eq;
  wire cl_wb    = (op == FCC_OP_FLUSHD || op == FCC_OP_FLUSHDA) && cl_match
                  && dc_val_q[ls_idx] && dc_dirty_q[ls_idx];
  wire [31:0] wb_addr = {dc_tag_q[d_idx_q], d_idx_q, d_cnt_q[2:0], 2'b00};
  wire [31:0] fill_addr = {ls_pa[31:OFFSET_W], d_cnt_q[2:0], 2'b00};

  assign dm_write      = ds_q == FCC_D_WBACK || (ds_q == FCC_D_BYP && op == FCC_OP_STORE);
  assign dm_read       = (ds_q == FCC_D_FILL && d_cnt_q < 4'(LINE_WORDS))
                         || (ds_q == FCC_D_BYP && op == FCC_OP_LOAD && d_cnt_q == 4'h0);
  assign dm_address    = ds_q == FCC_D_WBACK ? wb_addr : ds_q == FCC_D_FILL ? fill_addr : ls_pa;
  assign dm_writedata  = ds_q == FCC_D_WBACK ? dc_data_q[{d_idx_q, d_cnt_q[2:0]}] : ls_wdata;
  assign dm_byteenable = ds_q == FCC_D_WBACK ? 4'hF : ls_be;
  assign dtcm_read       = (d_go && op == FCC_OP_LOAD) ? ls_tsel : '0;
  assign dtcm_write      = (d_go && op == FCC_OP_STORE) ? ls_tsel : '0;
  assign dtcm_address    = ls_pa;
  assign dtcm_writedata  = ls_wdata;
  assign dtcm_byteenable = ls_be;
  assign ls_fault = (HAS_MMU != 0) && d_need && !mtlb_hit;

  // byte merge of a store into a cached word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) merge[b*8 +: 8] = be[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dc_val_q <= '0; dc_dirty_q <= '0;
      ds_q <= FCC_D_IDLE; d_cnt_q <= '0; d_got_q <= '0; d_idx_q <= '0; d_fill_q <= 1'b0;
      ls_ack <= 1'b0; ls_rdata <= '0;
    end
    else
    begin
      ls_ack <= 1'b0;
      unique case (ds_q)
        FCC_D_IDLE:
          if (d_go)
          begin
            d_cnt_q <= '0; d_got_q <= '0; d_idx_q <= ls_idx;
            if (d_tcm || (!is_mem && !cl_match))
            begin
              // RQ17 tcm access or no matching line, caches untouched
              ls_ack <= 1'b1;
              for (int k = 0; k < N_DTCM; k++)
                if (ls_tsel[k]) ls_rdata <= dtcm_readdata[k*32 +: 32];
            end
            // RQ12 bypass straight to the master
            else if (is_mem && d_byp) ds_q <= FCC_D_BYP;
            else if (!is_mem)
            begin
              if (cl_wb) ds_q <= FCC_D_WBACK;
              else
              begin
                dc_val_q[ls_idx] <= 1'b0; dc_dirty_q[ls_idx] <= 1'b0; ls_ack <= 1'b1;
              end
              d_fill_q <= 1'b0;
            end
            else if (d_tag_eq)
            begin
              ls_ack <= 1'b1;
              ls_rdata <= dc_data_q[{ls_idx, ls_word}];
              if (op == FCC_OP_STORE)
              begin
                dc_data_q[{ls_idx, ls_word}] <= merge(dc_data_q[{ls_idx, ls_word}], ls_wdata, ls_be);
                dc_dirty_q[ls_idx] <= 1'b1;
              end
            end
            else
            begin
              // RQ8 miss allocates for loads and stores; a dirty victim is written back first
              d_fill_q <= 1'b1;
              ds_q <= (dc_val_q[ls_idx] && dc_dirty_q[ls_idx]) ? FCC_D_WBACK : FCC_D_FILL;
            end
          end
        FCC_D_WBACK:
          if (!dm_waitrequest)
          begin
            d_cnt_q <= d_cnt_q + 4'h1;
            if (d_cnt_q == 4'(LINE_WORDS - 1))
            begin
              d_cnt_q <= '0;
              dc_dirty_q[d_idx_q] <= 1'b0;
              dc_val_q[d_idx_q] <= 1'b0;
              ds_q <= d_fill_q ? FCC_D_FILL : FCC_D_DONE;
            end
          end
        FCC_D_FILL:
        begin
          // RQ9 one read per clock, pipelined
          if (dm_read && !dm_waitrequest) d_cnt_q <= d_cnt_q + 4'h1;
          if (dm_readdatavalid)
          begin
            dc_data_q[{d_idx_q, d_got_q[2:0]}] <= dm_readdata;
            d_got_q <= d_got_q + 4'h1;
            if (d_got_q == 4'(LINE_WORDS - 1))
            begin
              dc_tag_q[d_idx_q] <= ls_tag;
              dc_val_q[d_idx_q] <= 1'b1;
              ds_q <= FCC_D_IDLE;
            end
          end
        end
        FCC_D_BYP:
          if (op == FCC_OP_STORE && !dm_waitrequest) ds_q <= FCC_D_DONE;
          else if (dm_read && !dm_waitrequest) d_cnt_q <= 4'h1;
          else if (dm_readdatavalid)
          begin
            ls_rdata <= dm_readdata;
            ds_q <= FCC_D_DONE;
          end
        FCC_D_DONE:
        begin
          ls_ack <= 1'b1;
          ds_q <= FCC_D_IDLE;
        end
        default: ds_q <= FCC_D_IDLE;
      endcase
    end
  end
endmodule // fcc_core_mem

// *** tb/fcc_mem_model.sv ***
// partner: pipelined memory-mapped slave with two-cycle read latency and stalls
module fcc_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] address,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic             waitrequest,
  output logic             readdatavalid,
  output logic [31:0]      readdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] q1_q, q2_q, cur, m;
  logic        v1_q = 1'b0, v2_q = 1'b0, ph_q = 1'b0;
  // stall every other cycle when slow, so held requests are exercised
  assign waitrequest   = slow & ph_q;
  assign readdatavalid = v2_q;
  // idle bus shows the inverse, never a stale word
  assign readdata      = v2_q ? q2_q : ~q2_q;
  assign m = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  always @(posedge clk)
  begin
    cur = mem.exists(address) ? mem[address] : address ^ 32'h5A5A_0000;
    ph_q <= ~ph_q;
    v1_q <= ~rst & read & ~waitrequest;
    v2_q <= ~rst & v1_q;
    q1_q <= cur;
    if (v1_q)
      q2_q <= q1_q;
    if (write && !waitrequest)
      mem[address] = (cur & ~m) | (writedata & m);
  end
endmodule // fcc_mem_model

// *** tb/fcc_chk.sv ***
// checker: port properties of the cache and tcm subsystem
module fcc_chk #(
  parameter int          N_ITCM    = 1,
  parameter int          N_DTCM    = 1,
  parameter logic [31:0] ITCM_BASE = 32'h0001_0000,
  parameter logic [31:0] DTCM_BASE = 32'h0002_0000,
  parameter logic [31:0] TCM_SPAN  = 32'h0000_1000
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [31:0]          if_addr,
  input wire logic                 if_ack,
  input wire logic [31:0]          if_rdata,
  input wire logic                 ls_ack,
  input wire logic                 im_read,
  input wire logic [31:0]          im_address,
  input wire logic                 im_waitrequest,
  input wire logic                 dm_read,
  input wire logic                 dm_write,
  input wire logic [31:0]          dm_address,
  input wire logic                 dm_waitrequest,
  input wire logic [N_ITCM-1:0]    itcm_read,
  input wire logic [31:0]          itcm_address,
  input wire logic [N_ITCM*32-1:0] itcm_readdata
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ILIM = 32'(N_ITCM) * TCM_SPAN;
  localparam logic [31:0] DLIM = 32'(N_DTCM) * TCM_SPAN;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence im_acc; im_read && !im_waitrequest; endsequence
  sequence dm_acc; dm_read && !dm_waitrequest; endsequence
  reset_idle_a: assert property ($fell(rst) |-> !if_ack && !ls_ack && !im_read && !dm_read)
    else $error("activity right after reset");
  crit_word_a: assert property ($rose(im_read) |-> im_address[31:2] == if_addr[31:2])
    else $error("fill does not start at fetched word");
  im_step_a: assert property (im_acc ##1 im_read |-> im_address[4:2] ==
    3'($past(im_address[4:2]) + 3'h1)) else $error("fetch fill word order");
  dm_step_a: assert property (dm_acc ##1 dm_read |-> dm_address == $past(dm_address) + 32'h4)
    else $error("data fill word order");
  itcm_span_a: assert property (itcm_read[0] |-> itcm_address - ITCM_BASE < ILIM)
    else $error("tcm read outside span");
  im_skip_a: assert property (im_read |-> im_address - ITCM_BASE >= ILIM)
    else $error("tcm fetch on master");
  dm_skip_a: assert property ((dm_read || dm_write) |-> dm_address - DTCM_BASE >= DLIM)
    else $error("tcm access on master");
  itcm_answer_a: assert property (itcm_read[0] |=> if_ack && if_rdata ==
    $past(itcm_readdata[31:0])) else $error("tcm fetch answer wrong");
endmodule // fcc_chk

bind fcc_core_mem fcc_chk #(.N_ITCM(N_ITCM), .N_DTCM(N_DTCM), .ITCM_BASE(ITCM_BASE),
  .DTCM_BASE(DTCM_BASE), .TCM_SPAN(TCM_SPAN)) u_chk (.clk, .rst, .if_addr, .if_ack, .if_rdata,
  .ls_ack, .im_read, .im_address, .im_waitrequest, .dm_read, .dm_write, .dm_address,
  .dm_waitrequest, .itcm_read, .itcm_address, .itcm_readdata);

// *** tb/fcc_core_mem_bench.sv ***
// bench: self-checking test of the cache, tcm and micro-tlb subsystem
module fcc_core_mem_bench
  import fcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
  logic             clk = 1'b0, rst = 1'b1, slow = 1'b0, if_req = 1'b0, ls_req = 1'b0;
  logic             ls_bypass = 1'b0, tlb_write = 1'b0, tlbmisc_write = 1'b0;
  logic             supervisor = 1'b1, mtlb_hit = 1'b0, if_ack, if_fault, ls_ack, ls_fault;
  logic             mtlb_req, im_read, im_waitrequest, im_readdatavalid, dm_read, dm_write;
  logic             dm_waitrequest, dm_readdatavalid;
  logic [2:0]       ls_op = 3'h0;
  logic [3:0]       ls_be = 4'hF, dm_byteenable, dtcm_byteenable;
  logic [0:0]       itcm_read, dtcm_read, dtcm_write;
  logic [VPN_W-1:0] mtlb_vpn;
  logic [PFN_W-1:0] mtlb_pfn = '0;
  logic [31:0]      if_addr = 32'h0, ls_addr = 32'h0, ls_wdata = 32'h0, rd, if_rdata, ls_rdata;
  logic [31:0]      im_address, im_readdata, dm_address, dm_writedata, dm_readdata;
  logic [31:0]      itcm_address, itcm_readdata, dtcm_address, dtcm_writedata, dtcm_readdata;
  int               miscompares = 0, cmp_count = 0;
  typedef struct packed {
    logic f; logic [2:0] op; logic byp; logic [31:0] a; logic [31:0] wd; logic c; logic [31:0] e;
  } fcc_row_t;
  fcc_row_t rows [18];
  function automatic logic [31:0] pat(input logic [31:0] a); return a ^ 32'h5A5A_0000; endfunction
  function automatic logic [31:0] tp(input logic [31:0] a); return a ^ 32'h0F0F_0000; endfunction
  fcc_core_mem DUT (.*);
  fcc_mem_model u_im (.clk, .rst, .slow, .read(im_read), .write(1'b0), .address(im_address),
    .writedata(32'h0), .byteenable(4'hF), .waitrequest(im_waitrequest),
    .readdatavalid(im_readdatavalid), .readdata(im_readdata));
  fcc_mem_model u_dm (.clk, .rst, .slow, .read(dm_read), .write(dm_write), .address(dm_address),
    .writedata(dm_writedata), .byteenable(dm_byteenable), .waitrequest(dm_waitrequest),
    .readdatavalid(dm_readdatavalid), .readdata(dm_readdata));
  // tcm slaves answer in the same cycle; unselected they show the inverse
  assign itcm_readdata = itcm_read[0] ? tp(itcm_address) : ~tp(itcm_address);
  assign dtcm_readdata = dtcm_read[0] ? tp(dtcm_address) : ~tp(dtcm_address);
  always #5 clk = ~clk;
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // idle cycle between requests keeps one assignment per time step
  task automatic xfer(input logic f, input logic [2:0] op, input logic byp,
                      input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(negedge clk);
    {if_req, ls_req, if_addr, ls_addr, ls_op, ls_bypass, ls_wdata} = {f, ~f, a, a, op, byp, wd};
    do @(negedge clk); while ((f ? if_ack : ls_ack) !== 1'b1 && ++n < 400);
    rd = f ? if_rdata : ls_rdata;
    {if_req, ls_req} = 2'h0;
    if (n >= 400)
    begin
      $display("Error %0t: no ack", $time);
      miscompares++;
      test_done();
    end
  endtask
  initial
  begin
    rows = '{'{1, 0, 0, 32'h10004, 0, 1, tp(32'h10004)}, '{1, 0, 0, 32'h40C, 0, 1, pat(32'h40C)},
      '{0, 0, 0, 32'h20008, 0, 1, tp(32'h20008)}, '{0, 2, 0, 32'h20008, 0, 0, 0},
      '{0, 0, 0, 32'h804, 0, 1, pat(32'h804)}, '{0, 1, 0, 32'h808, 32'hC0DE, 0, 0},
      '{0, 0, 0, 32'h808, 0, 1, 32'hC0DE}, '{0, 0, 1, 32'h808, 0, 1, pat(32'h808)},
      '{0, 3, 0, 32'h808, 0, 0, 0}, '{0, 0, 1, 32'h808, 0, 1, 32'hC0DE},
      '{0, 1, 0, 32'hC20, 32'hBEEF, 0, 0}, '{0, 4, 0, 32'hC20, 0, 0, 0},
      '{0, 0, 0, 32'hC20, 0, 1, pat(32'hC20)}, '{0, 1, 0, 32'hF60, 32'h2222, 0, 0},
      '{0, 5, 0, 32'hF60, 0, 0, 0}, '{0, 0, 0, 32'hF60, 0, 1, pat(32'hF60)},
      '{0, 1, 0, 32'h1080, 32'hAAAA, 0, 0}, '{0, 0, 0, 32'h1280, 0, 1, pat(32'h1280)}};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i])
    begin
      xfer(rows[i].f, rows[i].op, rows[i].byp, rows[i].a, rows[i].wd);
      if (rows[i].c)
        `CHK(rd, rows[i].e)
    end
    // dirty line lost to replacement must reach memory
    xfer(0, 3'h0, 1, 32'h1080, 32'h0);
    `CHK(rd, 32'hAAAA)
    xfer(0, 3'h1, 0, 32'h1300, 32'h5555);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK({if_ack, ls_ack, im_read, dm_read, dm_write}, 5'h0)
    xfer(0, 3'h0, 0, 32'h1300, 32'h0);
    `CHK(rd, pat(32'h1300))
    slow = 1'b1;
    xfer(1, 3'h0, 0, 32'h614, 32'h0);
    `CHK(rd, pat(32'h614))
    xfer(0, 3'h0, 0, 32'h1404, 32'h0);
    `CHK(rd, pat(32'h1404))
    slow = 1'b0;
    tlb_write = 1'b1;
    @(negedge clk);
    tlb_write = 1'b0;
    tlbmisc_write = 1'b1;
    @(negedge clk);
    tlbmisc_write = 1'b0;
    xfer(1, 3'h0, 0, 32'h10008, 32'h0);
    `CHK({rd, if_fault, ls_fault, mtlb_req}, {tp(32'h10008), 3'h0})
    test_done();
  end
endmodule // fcc_core_mem_bench
